/* File: logic/cam_ctrl_pkg.sv */
// Constants and types shared by the camera control register slice
`default_nettype none
package cam_ctrl_pkg;
    // Serial bus slave address (7 bits, write byte = {addr, 0}, read byte = {addr, 1})
    localparam logic [6:0] SLAVE_ADDR        = 7'h60;

    // Register subaddresses
    localparam logic [7:0] RED_BG_OFFS       = 8'h0d;
    localparam logic [7:0] GAIN_OFFS         = 8'h0e;
    localparam logic [7:0] LEVEL_OFFS        = 8'h0f;
    localparam logic [7:0] EXPOSURE_OFFS     = 8'h10;
    localparam logic [7:0] CLOCK_RATE_OFFS   = 8'h11;
    localparam logic [7:0] MODE_OFFS         = 8'h12;

    // Reset values
    localparam logic [7:0] RED_BG_RST        = 8'h20;
    localparam logic [7:0] GAIN_RST          = 8'h0d;
    localparam logic [7:0] LEVEL_RST         = 8'h05;
    localparam logic [7:0] EXPOSURE_RST      = 8'h9a;
    localparam logic [7:0] CLOCK_RATE_RST    = 8'h00;
    localparam logic [7:0] MODE_RST          = 8'h24;

    // Field positions
    localparam int RED_DIR_BIT               = 5;
    localparam int GAIN_DOUBLE_BIT           = 7;
    localparam int SYNC_POL_HI               = 7;
    localparam int SYNC_POL_LO               = 6;
    localparam int SOFT_RESET_BIT            = 7;
    localparam int MIRROR_BIT                = 6;
    localparam int AUTO_GAIN_BIT             = 5;
    localparam int YUV8_BIT                  = 4;
    localparam int RGB_BIT                   = 3;
    localparam int AUTO_BALANCE_BIT          = 2;
    localparam int COLOR_BAR_BIT             = 1;

    // Level selects in millivolts, indexed by the 2-bit code
    localparam logic [11:0] BLACK_MV [0:3]   = '{12'h4b0, 12'h4ec, 12'h514, 12'h578};
    localparam logic [11:0] HIGH_MV  [0:3]   = '{12'h76c, 12'h7d0, 12'h834, 12'h898};
    localparam logic [11:0] LOW_MV   [0:3]   = '{12'h514, 12'h5aa, 12'h5dc, 12'h640};

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX_ADDR, ST_RX_SUB, ST_RX_DATA, ST_ACK, ST_TX_DATA, ST_TX_HACK, ST_TX_NEXT
    } ser_state_t;
endpackage
`default_nettype wire

/* File: logic/clk_prescaler.sv */
// Internal clock divider: ref_clk / ((prescale + 1) * 2) / 2
`default_nettype none
module clk_prescaler (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [5:0] prescale,
    output var  logic       int_clk_out
);
    logic [6:0] half_cnt_r;
    logic [6:0] half_lim;

    // Half period is 2 * (prescale + 1) input cycles
    assign half_lim = {prescale, 1'b1};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            half_cnt_r  <= 7'h00;
            int_clk_out <= 1'b0;
        end else if (half_cnt_r >= half_lim) begin
            // Using >= lets a shrinking prescale take effect without a wrap
            half_cnt_r  <= 7'h00;
            int_clk_out <= ~int_clk_out;
        end else begin
            half_cnt_r  <= half_cnt_r + 7'h01;
        end
    end

    property p_half_period;
        @(posedge ref_clk) disable iff (sys_rst)
        ($changed(int_clk_out) && $stable(prescale)) |-> (half_cnt_r == 7'h00);
    endproperty
    a_half_period: assert property (p_half_period) else $error("prescaler toggled off count");

endmodule
`default_nettype wire

/* File: logic/camera_control_regs.sv */
// Camera control register slice 0x0d..0x12 behind a two-wire serial slave
`default_nettype none
// Notes on behaviour
// - Red background: reserved, direction, magnitude
// - Gain top bit doubles analog gain
// - Level bits 5:4 pick black expansion
// - Level bits 3:2 pick high threshold
// - Level bits 1:0 pick low threshold
// - Interlaced exposure is lines times value
// - Progressive exposure is twice that
// - Clock rate top bits set sync polarities
// - Internal clock divides by four times (prescale+1)
// - Soft reset restores defaults, bit self-clears
// - Mode bit 6 mirrors image
// - Mode bit 5 enables automatic gain
// - Mode bit 4 selects 8-bit luma/chroma order
// - Mode bit 3 selects RGB over YCrCb
// - Mode bit 2 enables auto colour balance
// - Mode bit 1 enables colour bar pattern
// - Write: subaddress then data; unmapped ignored
// - Read returns register at stored subaddress
module camera_control_regs (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    input  wire logic        progressive_mode,
    output var  logic        red_bg_raise,
    output var  logic [4:0]  red_background_adjust,
    output var  logic        analog_gain_double,
    output var  logic [11:0] black_level_mv,
    output var  logic [11:0] high_threshold_mv,
    output var  logic [11:0] low_threshold_mv,
    output var  logic [8:0]  exposure_period,
    output var  logic        hsync_positive,
    output var  logic        composite_line_sync_positive,
    output var  logic        vsync_positive,
    output var  logic        int_clk_out,
    output var  logic        chip_reset,
    output var  logic        mirror_select,
    output var  logic        auto_gain_enable,
    output var  logic        yuv8_output,
    output var  logic        rgb_select,
    output var  logic        auto_color_balance_enable,
    output var  logic        color_bar_enable
);
    logic [1:0]              scl_sync_r;
    logic [1:0]              sda_sync_r;
    logic                    scl_d_r;
    logic                    sda_d_r;
    logic                    scl_s;
    logic                    sda_s;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_det;
    logic                    stop_det;
    cam_ctrl_pkg::ser_state_t st_r;
    cam_ctrl_pkg::ser_state_t ack_next_r;
    logic                    ack_on_r;
    logic [2:0]              bit_cnt_r;
    logic [7:0]              shift_r;
    logic [7:0]              subaddr_r;
    logic [7:0]              rx_byte;
    logic [7:0]              rd_data;
    logic                    wr_fire;
    logic [5:0]              red_r;
    logic                    gain2x_r;
    logic [5:0]              level_r;
    logic [7:0]              exposure_value;
    logic [7:0]              clock_rate_reg;
    logic [6:1]              mode_r;
    logic                    soft_rst_r;
    logic                    regs_rst;

    // Pins are asynchronous to ref_clk; only stage 1 reads stage 0
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_pin};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r    <= scl_sync_r[1];
            sda_d_r    <= sda_sync_r[1];
        end
    end

    assign scl_s     = scl_sync_r[1];
    assign sda_s     = sda_sync_r[1];
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign rx_byte   = {shift_r[6:0], sda_s};

    // Data byte completes on its eighth rising clock edge
    assign wr_fire   = scl_rise && (st_r == cam_ctrl_pkg::ST_RX_DATA) && (bit_cnt_r == 3'h7);

    // Serial slave sequencer; sda only changes after scl falls
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r       <= cam_ctrl_pkg::ST_IDLE;
            ack_next_r <= cam_ctrl_pkg::ST_IDLE;
            ack_on_r   <= 1'b0;
            bit_cnt_r  <= 3'h0;
            shift_r    <= 8'h00;
            subaddr_r  <= 8'h00;
            sda_out    <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (start_det) begin
            st_r      <= cam_ctrl_pkg::ST_RX_ADDR;
            bit_cnt_r <= 3'h0;
            ack_on_r  <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (stop_det) begin
            st_r      <= cam_ctrl_pkg::ST_IDLE;
            ack_on_r  <= 1'b0;
            sda_oe    <= 1'b0;
        end else begin
            case (st_r)
                cam_ctrl_pkg::ST_RX_ADDR, cam_ctrl_pkg::ST_RX_SUB, cam_ctrl_pkg::ST_RX_DATA: begin
                    if (scl_rise) begin
                        shift_r   <= rx_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            st_r <= cam_ctrl_pkg::ST_ACK;
                            if (st_r == cam_ctrl_pkg::ST_RX_ADDR) begin
                                // Another slave's address: stay off the bus until next start
                                if (rx_byte[7:1] != cam_ctrl_pkg::SLAVE_ADDR) begin
                                    st_r <= cam_ctrl_pkg::ST_IDLE;
                                end
                                ack_next_r <= rx_byte[0] ? cam_ctrl_pkg::ST_TX_DATA : cam_ctrl_pkg::ST_RX_SUB;
                            end else if (st_r == cam_ctrl_pkg::ST_RX_SUB) begin
                                subaddr_r  <= rx_byte;
                                ack_next_r <= cam_ctrl_pkg::ST_RX_DATA;
                            end else begin
                                ack_next_r <= cam_ctrl_pkg::ST_RX_DATA;
                            end
                        end
                    end
                end
                cam_ctrl_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_r <= 1'b1;
                            sda_out  <= 1'b0;
                            sda_oe   <= 1'b1;
                        end else begin
                            ack_on_r <= 1'b0;
                            st_r     <= ack_next_r;
                            if (ack_next_r == cam_ctrl_pkg::ST_TX_DATA) begin
                                shift_r <= rd_data;
                                sda_out <= rd_data[7];
                                sda_oe  <= 1'b1;
                            end else begin
                                sda_oe  <= 1'b0;
                            end
                        end
                    end
                end
                cam_ctrl_pkg::ST_TX_DATA: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            st_r <= cam_ctrl_pkg::ST_TX_HACK;
                        end
                    end
                    if (scl_fall) begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_out <= shift_r[6];
                    end
                end
                cam_ctrl_pkg::ST_TX_HACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                    end
                    if (scl_rise) begin
                        // Host not-acknowledge ends the read
                        st_r <= sda_s ? cam_ctrl_pkg::ST_IDLE : cam_ctrl_pkg::ST_TX_NEXT;
                    end
                end
                cam_ctrl_pkg::ST_TX_NEXT: begin
                    if (scl_fall) begin
                        shift_r <= rd_data;
                        sda_out <= rd_data[7];
                        sda_oe  <= 1'b1;
                        st_r    <= cam_ctrl_pkg::ST_TX_DATA;
                    end
                end
                cam_ctrl_pkg::ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    st_r   <= cam_ctrl_pkg::ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Readback; reserved bits show their default, unmapped reads show zero
    always_comb begin
        case (subaddr_r)
            cam_ctrl_pkg::RED_BG_OFFS:     rd_data = {2'b00, red_r};
            cam_ctrl_pkg::GAIN_OFFS:       rd_data = {gain2x_r, cam_ctrl_pkg::GAIN_RST[6:0]};
            cam_ctrl_pkg::LEVEL_OFFS:      rd_data = {2'b00, level_r};
            cam_ctrl_pkg::EXPOSURE_OFFS:   rd_data = exposure_value;
            cam_ctrl_pkg::CLOCK_RATE_OFFS: rd_data = clock_rate_reg;
            cam_ctrl_pkg::MODE_OFFS:       rd_data = {soft_rst_r, mode_r, 1'b0};
            default:                       rd_data = 8'h00;
        endcase
    end

    assign regs_rst = sys_rst | soft_rst_r;

    // Soft reset request lives one cycle, then every register reloads
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_fire && (subaddr_r == cam_ctrl_pkg::MODE_OFFS)
                          && rx_byte[cam_ctrl_pkg::SOFT_RESET_BIT];
        end
    end

    // Register file; exposure and clock rate are read-only from the bus
    always_ff @(posedge ref_clk) begin
        if (regs_rst) begin
            red_r          <= cam_ctrl_pkg::RED_BG_RST[5:0];
            gain2x_r       <= cam_ctrl_pkg::GAIN_RST[cam_ctrl_pkg::GAIN_DOUBLE_BIT];
            level_r        <= cam_ctrl_pkg::LEVEL_RST[5:0];
            exposure_value <= cam_ctrl_pkg::EXPOSURE_RST;
            clock_rate_reg <= cam_ctrl_pkg::CLOCK_RATE_RST;
            mode_r         <= cam_ctrl_pkg::MODE_RST[6:1];
        end else if (wr_fire) begin
            case (subaddr_r)
                cam_ctrl_pkg::RED_BG_OFFS: red_r    <= rx_byte[5:0];
                cam_ctrl_pkg::GAIN_OFFS:   gain2x_r <= rx_byte[cam_ctrl_pkg::GAIN_DOUBLE_BIT];
                cam_ctrl_pkg::LEVEL_OFFS:  level_r  <= rx_byte[5:0];
                cam_ctrl_pkg::MODE_OFFS:   mode_r   <= rx_byte[6:1];
                default:                   red_r    <= red_r;
            endcase
        end
    end

    assign red_bg_raise              = red_r[cam_ctrl_pkg::RED_DIR_BIT];
    assign red_background_adjust     = red_r[4:0];
    assign analog_gain_double        = gain2x_r;
    assign mirror_select             = mode_r[cam_ctrl_pkg::MIRROR_BIT];
    assign auto_gain_enable          = mode_r[cam_ctrl_pkg::AUTO_GAIN_BIT];
    assign yuv8_output               = mode_r[cam_ctrl_pkg::YUV8_BIT];
    assign rgb_select                = mode_r[cam_ctrl_pkg::RGB_BIT];
    assign auto_color_balance_enable = mode_r[cam_ctrl_pkg::AUTO_BALANCE_BIT];
    assign color_bar_enable          = mode_r[cam_ctrl_pkg::COLOR_BAR_BIT];
    assign chip_reset                = soft_rst_r;

    // Decoded analog settings, one cycle behind their fields
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            black_level_mv               <= 12'h000;
            high_threshold_mv            <= 12'h000;
            low_threshold_mv             <= 12'h000;
            exposure_period              <= 9'h000;
            hsync_positive               <= 1'b0;
            composite_line_sync_positive <= 1'b0;
            vsync_positive               <= 1'b0;
        end else begin
            black_level_mv    <= cam_ctrl_pkg::BLACK_MV[level_r[5:4]];
            high_threshold_mv <= cam_ctrl_pkg::HIGH_MV[level_r[3:2]];
            low_threshold_mv  <= cam_ctrl_pkg::LOW_MV[level_r[1:0]];
            // Exposure is counted in line periods
            exposure_period   <= progressive_mode ? {exposure_value, 1'b0}
                                                  : {1'b0, exposure_value};
            hsync_positive               <= clock_rate_reg[cam_ctrl_pkg::SYNC_POL_HI];
            composite_line_sync_positive <= &clock_rate_reg[cam_ctrl_pkg::SYNC_POL_HI:cam_ctrl_pkg::SYNC_POL_LO];
            vsync_positive               <= clock_rate_reg[cam_ctrl_pkg::SYNC_POL_HI]
                                            | ~clock_rate_reg[cam_ctrl_pkg::SYNC_POL_LO];
        end
    end

    clk_prescaler u_prescaler (
        .ref_clk     (ref_clk),
        .sys_rst     (regs_rst),
        .prescale    (clock_rate_reg[5:0]),
        .int_clk_out (int_clk_out)
    );

    property p_red_write;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_fire && subaddr_r == cam_ctrl_pkg::RED_BG_OFFS)
            |=> ({red_bg_raise, red_background_adjust} == $past(rx_byte[5:0]));
    endproperty
    a_red_write: assert property (p_red_write) else $error("red background write lost");

    property p_gain_double;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_fire && subaddr_r == cam_ctrl_pkg::GAIN_OFFS) |=> (analog_gain_double == $past(rx_byte[7]));
    endproperty
    a_gain_double: assert property (p_gain_double) else $error("gain double bit wrong");

    property p_black_level;
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> black_level_mv == cam_ctrl_pkg::BLACK_MV[$past(level_r[5:4])];
    endproperty
    a_black_level: assert property (p_black_level) else $error("black level mismatch");

    property p_thresholds;
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> (high_threshold_mv == cam_ctrl_pkg::HIGH_MV[$past(level_r[3:2])])
                            && (low_threshold_mv == cam_ctrl_pkg::LOW_MV[$past(level_r[1:0])]);
    endproperty
    a_thresholds: assert property (p_thresholds) else $error("threshold level mismatch");

    property p_exposure;
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> exposure_period == ($past(progressive_mode) ? {$past(exposure_value), 1'b0}
                                                                        : {1'b0, $past(exposure_value)});
    endproperty
    a_exposure: assert property (p_exposure) else $error("exposure period wrong");

    property p_sync_pol;
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> {hsync_positive, composite_line_sync_positive, vsync_positive}
            == (($past(clock_rate_reg[7:6]) == 2'b00) ? 3'b001 : ($past(clock_rate_reg[7:6]) == 2'b01) ? 3'b000
                : ($past(clock_rate_reg[7:6]) == 2'b10) ? 3'b101 : 3'b111);
    endproperty
    a_sync_pol: assert property (p_sync_pol) else $error("sync polarity wrong");

    property p_soft_reset;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_fire && subaddr_r == cam_ctrl_pkg::MODE_OFFS && rx_byte[7])
            |=> chip_reset ##1 (!chip_reset && mode_r == cam_ctrl_pkg::MODE_RST[6:1]
                                && red_r == cam_ctrl_pkg::RED_BG_RST[5:0]);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong");

    property p_unmapped;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_fire && (subaddr_r < cam_ctrl_pkg::RED_BG_OFFS || subaddr_r > cam_ctrl_pkg::MODE_OFFS))
            |=> $stable({red_r, gain2x_r, level_r, mode_r});
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");

    property p_read_first_bit;
        @(posedge ref_clk) disable iff (sys_rst)
        ((st_r == cam_ctrl_pkg::ST_TX_NEXT || (st_r == cam_ctrl_pkg::ST_ACK && ack_on_r
          && ack_next_r == cam_ctrl_pkg::ST_TX_DATA)) && scl_fall && !start_det && !stop_det)
            |=> sda_oe && sda_out == $past(rd_data[7]);
    endproperty
    a_read_first_bit: assert property (p_read_first_bit) else $error("read data not driven");

endmodule
`default_nettype wire

/* File: tb/serial_host.sv */
// Behavioural two-wire host that drives the serial control pins
`default_nettype none
module serial_host (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    int miss;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        miss = 0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data moves 2 clocks after scl falls so the synchronisers never see it race the clock
    task automatic clk_bit(input logic b, output logic s);
        gap(2);
        sda <= b;
        gap(8);
        scl <= 1'b1;
        gap(8);
        s = sda_line;
        scl <= 1'b0;
    endtask
    task automatic start;
        sda <= 1'b1;
        scl <= 1'b1;
        gap(8);
        sda <= 1'b0;
        gap(8);
        scl <= 1'b0;
    endtask
    task automatic stop;
        gap(2);
        sda <= 1'b0;
        gap(8);
        scl <= 1'b1;
        gap(8);
        sda <= 1'b1;
        gap(8);
    endtask
    task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
        clk_bit(last, a);
        if (last && a) miss++;
    endtask
    task automatic write_reg(input logic [7:0] sub, input logic [7:0] data);
        logic [7:0] q;
        start();
        byte_x(8'hc0, 1'b1, q);
        byte_x(sub, 1'b1, q);
        byte_x(data, 1'b1, q);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] sub, output logic [7:0] q);
        logic [7:0] d;
        start();
        byte_x(8'hc0, 1'b1, d);
        byte_x(sub, 1'b1, d);
        stop();
        start();
        byte_x(8'hc1, 1'b1, d);
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, q[i]);
        clk_bit(1'b1, d[0]);
        stop();
    endtask
endmodule
`default_nettype wire

/* File: tb/camera_control_regs_tb.sv */
// Self-checking bench for the camera control register slice
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module camera_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, sys_rst, progressive_mode, scl, sda, sda_out, sda_oe, sda_line;
    logic        red_bg_raise, analog_gain_double, hsync_positive, composite_line_sync_positive;
    logic        vsync_positive, int_clk_out, chip_reset, mirror_select, auto_gain_enable;
    logic        yuv8_output, rgb_select, auto_color_balance_enable, color_bar_enable;
    logic [4:0]  red_background_adjust;
    logic [8:0]  exposure_period;
    logic [11:0] black_level_mv, high_threshold_mv, low_threshold_mv;
    logic [5:0]  mode_bits;
    logic [7:0]  q;
    int          bad_count, checks, pulses;
    localparam logic [7:0]  DEF [0:5] = '{8'h20, 8'h0d, 8'h05, 8'h9a, 8'h00, 8'h24};
    localparam logic [11:0] BLK [0:3] = '{12'h4b0, 12'h4ec, 12'h514, 12'h578};
    localparam logic [11:0] HI  [0:3] = '{12'h76c, 12'h7d0, 12'h834, 12'h898};
    localparam logic [11:0] LO  [0:3] = '{12'h514, 12'h5aa, 12'h5dc, 12'h640};
    // Open drain wire with pull-up: either party may only pull it low
    assign sda_line = sda & ~(sda_oe & ~sda_out);
    assign mode_bits = {mirror_select, auto_gain_enable, yuv8_output, rgb_select,
                        auto_color_balance_enable, color_bar_enable};
    serial_host u_host (.ref_clk, .sda_line, .scl, .sda);
    camera_control_regs u_dut (.ref_clk, .sys_rst, .scl_pin(scl), .sda_in(sda_line), .sda_out, .sda_oe,
        .progressive_mode, .red_bg_raise, .red_background_adjust, .analog_gain_double, .black_level_mv,
        .high_threshold_mv, .low_threshold_mv, .exposure_period, .hsync_positive,
        .composite_line_sync_positive, .vsync_positive, .int_clk_out, .chip_reset, .mirror_select,
        .auto_gain_enable, .yuv8_output, .rgb_select, .auto_color_balance_enable, .color_bar_enable);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (chip_reset === 1'b1) pulses++;
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_defaults;
        time t0;
        for (int i = 0; i < 6; i++) begin
            u_host.read_reg(8'h0d + 8'(i), q);
            `CHK(q, DEF[i])
        end
        `CHK({hsync_positive, composite_line_sync_positive, vsync_positive}, 3'b001)
        `CHK(exposure_period, 9'h09a)
        `CHK(mode_bits, 6'h12)
        @(posedge int_clk_out);
        t0 = $time;
        @(posedge int_clk_out);
        `CHK(32'(($time - t0) / 25), 32'h4)
        $display("t_defaults done");
    endtask
    task automatic t_fields;
        u_host.write_reg(8'h0d, 8'hff);
        u_host.read_reg(8'h0d, q);
        `CHK(q, 8'h3f)
        `CHK({red_bg_raise, red_background_adjust}, 6'h3f)
        u_host.write_reg(8'h0d, 8'ha5);
        `CHK({red_bg_raise, red_background_adjust}, 6'h25)
        u_host.write_reg(8'h0e, 8'hff);
        `CHK(analog_gain_double, 1'b1)
        u_host.write_reg(8'h0e, 8'h00);
        `CHK(analog_gain_double, 1'b0)
        for (int i = 0; i < 4; i++) begin
            u_host.write_reg(8'h0f, {2'b11, 2'(i), 2'(i), 2'(i)});
            `CHK(black_level_mv, BLK[i])
            `CHK(high_threshold_mv, HI[i])
            `CHK(low_threshold_mv, LO[i])
        end
        $display("t_fields done");
    endtask
    task automatic t_readonly;
        u_host.write_reg(8'h10, 8'h00);
        u_host.write_reg(8'h11, 8'hc0);
        u_host.write_reg(8'h20, 8'h55);
        u_host.read_reg(8'h10, q);
        `CHK(q, 8'h9a)
        u_host.read_reg(8'h11, q);
        `CHK(q, 8'h00)
        u_host.read_reg(8'h0f, q);
        `CHK(q, 8'h3f)
        progressive_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(exposure_period, 9'h134)
        progressive_mode <= 1'b0;
        $display("t_readonly done");
    endtask
    task automatic t_mode;
        u_host.write_reg(8'h12, 8'h7e);
        `CHK(mode_bits, 6'h3f)
        u_host.write_reg(8'h12, 8'h02);
        `CHK(mode_bits, 6'h01)
        pulses = 0;
        u_host.write_reg(8'h12, 8'h80);
        `CHK(pulses, 1)
        u_host.read_reg(8'h0d, q);
        `CHK(q, 8'h20)
        u_host.read_reg(8'h12, q);
        `CHK(q, 8'h24)
        `CHK(u_host.miss, 0)
        $display("t_mode done");
    endtask
    initial begin
        // Bus-level run is about 16k clocks; 40k clocks means a hang
        #1_000_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        bad_count = 0;
        checks = 0;
        pulses = 0;
        sys_rst = 1'b1;
        progressive_mode = 1'b0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_defaults();
        t_fields();
        t_readonly();
        t_mode();
        report_and_stop();
    end
endmodule
`default_nettype wire
